// ---- aesinv_pkg.sv ----
/*
 * Constants, lookup tables and byte-field helpers for the inverse round datapath.
 * Assumes a single clock domain; every function here is pure combinational logic.
 */
// How it works
// - word_substitute maps each byte of a word through the forward table, in place.
// - column_unmix output byte is XOR of field products, coefficients 0E 0B 0D 09 rotated.
// - column_unmix undoes column_mix exactly.
// - row_unrotate keeps row 0, rotates rows 1..3 right by 1, 2, 3 bytes.
// - byte_unsubstitute maps every state byte through the inverse table, nibble indexed.
// - inverse table is the exact inverse of forward: 00->52, 01->09, 02->6A.
// - carryless_mul_64 multiplies two 64-bit polynomials over GF(2) into 128 bits.
// - feature word bit 25 reports round support; caller checks it first.
// - feature word bit 1 reports carryless_mul_64; caller checks it first.
// - field_multiply is carry-less byte product reduced by x^8+x^4+x^3+x+1.
// - state byte 4c+r is row r, column c.
// - forward table is the standard substitution table: 00->63, 01->7C.
`default_nettype none

package aesinv_pkg;

    localparam logic [2:0] AESINV_OP_UNMIX   = 3'h0;
    localparam logic [2:0] AESINV_OP_UNROT   = 3'h1;
    localparam logic [2:0] AESINV_OP_UNSUB   = 3'h3;
    localparam logic [2:0] AESINV_OP_WORDSUB = 3'h2;
    localparam logic [2:0] AESINV_OP_CLMUL   = 3'h6;

    localparam logic [7:0] AESINV_REDUCE     = 8'h1B;
    localparam logic [7:0] AESINV_C0         = 8'h0E;
    localparam logic [7:0] AESINV_C1         = 8'h0B;
    localparam logic [7:0] AESINV_C2         = 8'h0D;
    localparam logic [7:0] AESINV_C3         = 8'h09;
    localparam logic [7:0] AESINV_MIX2       = 8'h02;
    localparam logic [7:0] AESINV_MIX3       = 8'h03;

    localparam int AESINV_ROUND_BIT = 25;
    localparam int AESINV_CLMUL_BIT = 1;
    localparam logic [31:0] AESINV_FEATURE_RST = 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // entry 0 sits in the top byte of each constant
    localparam logic [2047:0] AESINV_FWD_TBL = {
        128'h637C777BF26B6FC53001672BFED7AB76, 128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
        128'hB7FD9326363FF7CC34A5E5F171D83115, 128'h04C723C31896059A071280E2EB27B275,
        128'h09832C1A1B6E5AA0523BD6B329E32F84, 128'h53D100ED20FCB15B6ACBBE394A4C58CF,
        128'hD0EFAAFB434D338545F9027F503C9FA8, 128'h51A3408F929D38F5BCB6DA2110FFF3D2,
        128'hCD0C13EC5F974417C4A77E3D645D1973, 128'h60814FDC222A908846EEB814DE5E0BDB,
        128'hE0323A0A4906245CC2D3AC629195E479, 128'hE7C8376D8DD54EA96C56F4EA657AAE08,
        128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A, 128'h703EB5664803F60E613557B986C11D9E,
        128'hE1F8981169D98E949B1E87E9CE5528DF, 128'h8CA1890DBFE6426841992D0FB054BB16};

    localparam logic [2047:0] AESINV_INV_TBL = {
        128'h52096AD53036A538BF40A39E81F3D7FB, 128'h7CE339829B2FFF87348E4344C4DEE9CB,
        128'h547B9432A6C2233DEE4C950B42FAC34E, 128'h082EA16628D924B2765BA2496D8BD125,
        128'h72F8F66486689816D4A45CCC5D65B692, 128'h6C704850FDEDB9DA5E154657A78D9D84,
        128'h90D8AB008CBCD30AF7E45805B8B34506, 128'hD02C1E8FCA3F0F02C1AFBD0301138A6B,
        128'h3A9111414F67DCEA97F2CFCEF0B4E673, 128'h96AC7422E7AD3585E2F937E81C75DF6E,
        128'h47F11A711D29C5896FB7620EAA18BE1B, 128'hFC563E4BC6D279209ADBC0FE78CD5AF4,
        128'h1FDDA8338807C731B11210592780EC5F, 128'h60517FA919B54A0D2DE57A9F93C99CEF,
        128'hA0E03B4DAE2AF5B0C8EBBB3C83539961, 128'h172B047EBA77D626E169146355210C7D};

    function automatic logic [7:0] fwd_lookup(input logic [7:0] b);
        fwd_lookup = AESINV_FWD_TBL[2047 - 8 * b -: 8];
    endfunction

    function automatic logic [7:0] inv_lookup(input logic [7:0] b);
        // upper nibble picks the row, lower the column: one flat index
        inv_lookup = AESINV_INV_TBL[2047 - 8 * b -: 8];
    endfunction

    function automatic logic [7:0] field_multiply(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] acc;
        logic [7:0] sh;
        acc = 8'h00;
        sh  = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                acc = acc ^ sh;
            end
            sh = {sh[6:0], 1'b0} ^ (sh[7] ? AESINV_REDUCE : 8'h00);
        end
        field_multiply = acc;
    endfunction

    function automatic logic [127:0] column_mix(input logic [127:0] s);
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        column_mix = '0;
        for (int c = 0; c < 4; c++) begin
            b0 = s[32*c +: 8];
            b1 = s[32*c+8 +: 8];
            b2 = s[32*c+16 +: 8];
            b3 = s[32*c+24 +: 8];
            column_mix[32*c +: 8]    = field_multiply(AESINV_MIX2, b0)
                                     ^ field_multiply(AESINV_MIX3, b1) ^ b2 ^ b3;
            column_mix[32*c+8 +: 8]  = b0 ^ field_multiply(AESINV_MIX2, b1)
                                     ^ field_multiply(AESINV_MIX3, b2) ^ b3;
            column_mix[32*c+16 +: 8] = b0 ^ b1 ^ field_multiply(AESINV_MIX2, b2)
                                     ^ field_multiply(AESINV_MIX3, b3);
            column_mix[32*c+24 +: 8] = field_multiply(AESINV_MIX3, b0) ^ b1 ^ b2
                                     ^ field_multiply(AESINV_MIX2, b3);
        end
    endfunction

endpackage

`default_nettype wire

// ---- aesinv_core.sv ----
/*
 * Inverse round datapath: column_unmix, row_unrotate, byte_unsubstitute,
 * word_substitute and carryless_mul_64, one result register.
 * Assumes operands are synchronous to CORE_CLK and stable while IN_VALID is high.
 */
`timescale 1ns/10ps
`default_nettype none

module aesinv_core (
    input  wire logic         CORE_CLK,
    input  wire logic         RST,
    input  wire logic         CE,
    input  wire logic         IN_VALID,
    input  wire logic [2:0]   OP_SEL,
    input  wire logic [127:0] STATE_IN,
    input  wire logic [31:0]  WORD_IN,
    input  wire logic [63:0]  OPND_A,
    input  wire logic [63:0]  OPND_B,
    output logic              OUT_VALID,
    output logic [127:0]      RESULT,
    output logic [31:0]       FEATURE_ECX
);

    typedef enum logic [2:0] {
        AESINV_UNMIX   = aesinv_pkg::AESINV_OP_UNMIX,
        AESINV_UNROT   = aesinv_pkg::AESINV_OP_UNROT,
        AESINV_WORDSUB = aesinv_pkg::AESINV_OP_WORDSUB,
        AESINV_UNSUB   = aesinv_pkg::AESINV_OP_UNSUB,
        AESINV_CLMUL   = aesinv_pkg::AESINV_OP_CLMUL
    } aesinv_op_t;

    logic             valid_q;
    logic             valid_d;
    logic [127:0]     res_q;
    logic [127:0]     res_d;
    logic [127:0]     unmix_v;
    logic [127:0]     unrot_v;
    logic [127:0]     unsub_v;
    logic [31:0]      wsub_v;
    logic [127:0]     clmul_v;
    aesinv_op_t       op;

    assign op = aesinv_op_t'(OP_SEL);

    ////////////////////////////////////////////////////////////////////////////
    // transforms; byte 4c+r is row r of column c
    always_comb begin
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        b0 = 8'h00;
        b1 = 8'h00;
        b2 = 8'h00;
        b3 = 8'h00;
        unmix_v = '0;
        unrot_v = '0;
        unsub_v = '0;
        wsub_v  = '0;
        clmul_v = '0;
        for (int c = 0; c < 4; c++) begin
            b0 = STATE_IN[32*c +: 8];
            b1 = STATE_IN[32*c+8 +: 8];
            b2 = STATE_IN[32*c+16 +: 8];
            b3 = STATE_IN[32*c+24 +: 8];
            unmix_v[32*c +: 8] = aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C0, b0)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C1, b1)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C2, b2)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C3, b3);
            unmix_v[32*c+8 +: 8] = aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C3, b0)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C0, b1)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C1, b2)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C2, b3);
            unmix_v[32*c+16 +: 8] = aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C2, b0)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C3, b1)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C0, b2)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C1, b3);
            unmix_v[32*c+24 +: 8] = aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C1, b0)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C2, b1)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C3, b2)
                ^ aesinv_pkg::field_multiply(aesinv_pkg::AESINV_C0, b3);
            for (int r = 0; r < 4; r++) begin
                // right rotation: output column c takes input column c-r
                unrot_v[32*c+8*r +: 8] = STATE_IN[32*((c-r+4)%4)+8*r +: 8];
                unsub_v[32*c+8*r +: 8] = aesinv_pkg::inv_lookup(STATE_IN[32*c+8*r +: 8]);
            end
            wsub_v[8*c +: 8] = aesinv_pkg::fwd_lookup(WORD_IN[8*c +: 8]);
        end
        // full xor array; one level deep, so timing is the 64-input xor tree
        for (int i = 0; i < 64; i++) begin
            if (OPND_B[i]) begin
                clmul_v = clmul_v ^ ({64'h0, OPND_A} << i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result register
    always_comb begin
        valid_d = valid_q;
        res_d   = res_q;
        if (CE) begin
            valid_d = IN_VALID;
            if (IN_VALID) begin
                case (op)
                    AESINV_UNMIX:   res_d = unmix_v;
                    AESINV_UNROT:   res_d = unrot_v;
                    AESINV_UNSUB:   res_d = unsub_v;
                    AESINV_WORDSUB: res_d = {96'h0, wsub_v};
                    AESINV_CLMUL:   res_d = clmul_v;
                    default:        res_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            valid_q <= 1'b0;
            res_q   <= '0;
        end else begin
            valid_q <= valid_d;
            res_q   <= res_d;
        end
    end

    assign OUT_VALID = valid_q;
    assign RESULT    = res_q;

    // fixed capability word, valid from reset on
    always_comb begin
        FEATURE_ECX = aesinv_pkg::AESINV_FEATURE_RST;
        FEATURE_ECX[aesinv_pkg::AESINV_ROUND_BIT] = 1'b1;
        FEATURE_ECX[aesinv_pkg::AESINV_CLMUL_BIT] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    property p_valid_follows;
        CE && IN_VALID |=> OUT_VALID;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("no valid");

    property p_valid_one_cycle;
        CE && !IN_VALID |=> !OUT_VALID;
    endproperty
    a_valid_one_cycle: assert property (p_valid_one_cycle) else $error("valid stuck");

    property p_wordsub;
        CE && IN_VALID && OP_SEL == aesinv_pkg::AESINV_OP_WORDSUB |=>
            aesinv_pkg::inv_lookup(RESULT[7:0]) == $past(WORD_IN[7:0])
            && aesinv_pkg::inv_lookup(RESULT[31:24]) == $past(WORD_IN[31:24])
            && RESULT[127:32] == 96'h0;
    endproperty
    a_wordsub: assert property (p_wordsub) else $error("word substitution wrong");

    property p_unsub;
        CE && IN_VALID && OP_SEL == aesinv_pkg::AESINV_OP_UNSUB |=>
            aesinv_pkg::fwd_lookup(RESULT[15:8]) == $past(STATE_IN[15:8])
            && aesinv_pkg::fwd_lookup(RESULT[127:120]) == $past(STATE_IN[127:120]);
    endproperty
    a_unsub: assert property (p_unsub) else $error("inverse table mismatch");

    property p_unmix_inverse;
        CE && IN_VALID && OP_SEL == aesinv_pkg::AESINV_OP_UNMIX |=>
            aesinv_pkg::column_mix(RESULT) == $past(STATE_IN);
    endproperty
    a_unmix_inverse: assert property (p_unmix_inverse) else $error("unmix not inverse");

    property p_unrot;
        CE && IN_VALID && OP_SEL == aesinv_pkg::AESINV_OP_UNROT |=>
            RESULT[7:0] == $past(STATE_IN[7:0]) && RESULT[15:8] == $past(STATE_IN[111:104])
            && RESULT[23:16] == $past(STATE_IN[87:80])
            && RESULT[31:24] == $past(STATE_IN[63:56]);
    endproperty
    a_unrot: assert property (p_unrot) else $error("row rotation wrong");

    property p_clmul;
        CE && IN_VALID && OP_SEL == aesinv_pkg::AESINV_OP_CLMUL |=>
            RESULT[127] == 1'b0 && RESULT[126] == ($past(OPND_A[63]) & $past(OPND_B[63]))
            && RESULT[0] == ($past(OPND_A[0]) & $past(OPND_B[0]))
            && RESULT[1] == (($past(OPND_A[1]) & $past(OPND_B[0]))
                           ^ ($past(OPND_A[0]) & $past(OPND_B[1])));
    endproperty
    a_clmul: assert property (p_clmul) else $error("carry-less product wrong");

    property p_features;
        FEATURE_ECX[aesinv_pkg::AESINV_ROUND_BIT] && FEATURE_ECX[aesinv_pkg::AESINV_CLMUL_BIT];
    endproperty
    a_features: assert property (p_features) else $error("feature bits not set");

    property p_hold;
        !CE |=> $stable(RESULT) && $stable(OUT_VALID);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while frozen");

endmodule

`default_nettype wire

// ---- aesinv_pipe_model.sv ----
/*
 * pipeline-side partner: turns bench requests into the request strobe.
 * assumes the feature word is static and operands come straight from the bench.
 */
`timescale 1ns/10ps
`default_nettype none

module aesinv_pipe_model (
    input  wire logic [31:0] feature_ecx,
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_op,
    output logic             in_valid
);
    logic round_ok;
    logic clmul_ok;

    ////////////////////////////////////////////////////////////////////////////
    assign round_ok = feature_ecx[aesinv_pkg::AESINV_ROUND_BIT];
    assign clmul_ok = feature_ecx[aesinv_pkg::AESINV_CLMUL_BIT];
    // never issue a unit the device does not advertise
    assign in_valid = req_valid
                    & ((req_op == aesinv_pkg::AESINV_OP_CLMUL) ? clmul_ok : round_ok);
endmodule

`default_nettype wire

// ---- tb_aes_inverse_round_clmul.sv ----
/*
 * self-checking bench for the inverse round datapath, random plus corner cases.
 * assumes one result register, one cycle latency and a static feature word.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_aes_inverse_round_clmul;
    logic         core_clk;
    logic         rst;
    logic         ce;
    logic         req_valid;
    logic         in_valid;
    logic [2:0]   op_sel;
    logic [127:0] state_in;
    logic [31:0]  word_in;
    logic [63:0]  opnd_a;
    logic [63:0]  opnd_b;
    logic         out_valid;
    logic [127:0] result;
    logic [31:0]  feature_ecx;
    logic [31:0]  seed = 32'h00004501;
    logic [7:0]   inv_t [256];
    logic [127:0] last_r;
    logic         last_v;
    logic [127:0] x;
    int           err_total = 0;
    int           checks = 0;

    aesinv_core aesinv_core_inst (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .IN_VALID(in_valid),
        .OP_SEL(op_sel), .STATE_IN(state_in), .WORD_IN(word_in), .OPND_A(opnd_a),
        .OPND_B(opnd_b), .OUT_VALID(out_valid), .RESULT(result), .FEATURE_ECX(feature_ecx));
    aesinv_pipe_model aesinv_pipe_model_inst (.feature_ecx(feature_ecx), .req_valid(req_valid),
        .req_op(op_sel), .in_valid(in_valid));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] fwd(input logic [7:0] b);
        return aesinv_pkg::AESINV_FWD_TBL[2047 - 8 * b -: 8];
    endfunction

    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            p ^= b[i] ? a : 8'h00;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
        end
        return p;
    endfunction

    // k holds the row-0 coefficients, byte 0 first; later rows rotate right
    function automatic logic [127:0] colmat(input logic [127:0] s, input logic [31:0] k);
        logic [127:0] o;
        o = '0;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                for (int j = 0; j < 4; j++)
                    o[32*c+8*r +: 8] ^= gm(k[8*((j-r+4)%4) +: 8], s[32*c+8*j +: 8]);
        return o;
    endfunction

    function automatic logic [127:0] expect_of(input logic [2:0] op, input logic [127:0] s);
        logic [127:0] o;
        o = '0;
        for (int i = 0; i < 64; i++) begin
            case (op)
                aesinv_pkg::AESINV_OP_CLMUL: o ^= s[64+i] ? ({64'h0, s[63:0]} << i) : '0;
                aesinv_pkg::AESINV_OP_UNSUB: o[8*(i%16) +: 8] = inv_t[s[8*(i%16) +: 8]];
                aesinv_pkg::AESINV_OP_WORDSUB: o[8*(i%4) +: 8] = fwd(s[8*(i%4) +: 8]);
                aesinv_pkg::AESINV_OP_UNROT: o[8*(i%16) +: 8] =
                    s[32*((i%16/4 - i%4 + 4)%4) + 8*(i%4) +: 8];
                default: o = o;
            endcase
        end
        return (op == aesinv_pkg::AESINV_OP_UNMIX) ? colmat(s, 32'h090D0B0E) : o;
    endfunction

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // drive 1 ns after an edge, check 1 ns after the next: back to back by default
    task automatic step(input logic [2:0] op, input logic [127:0] s, input logic en,
                        input logic req);
        logic [127:0] exp_r;
        logic         exp_v;
        req_valid = req;
        op_sel = op;
        ce = en;
        state_in = s;
        word_in = s[31:0];
        opnd_a = s[63:0];
        opnd_b = s[127:64];
        exp_r = (en && req) ? expect_of(op, s) : last_r;
        exp_v = en ? req : last_v;
        @(posedge core_clk);
        #1;
        chk(result, exp_r);
        chk({127'h0, out_valid}, {127'h0, exp_v});
        last_r = exp_r;
        last_v = exp_v;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        wrap_up();
    end

    initial begin
        {rst, ce, req_valid, op_sel, state_in, word_in, opnd_a, opnd_b} = '0;
        rst = 1'b1;
        last_r = '0;
        last_v = 1'b0;
        for (int i = 0; i < 256; i++) inv_t[fwd(i[7:0])] = i[7:0];
        repeat (10) @(posedge core_clk);
        #1;
        chk(result, 128'h0);
        chk({127'h0, out_valid}, 128'h0);
        rst = 1'b0;
        chk({96'h0, feature_ecx}, {96'h0, 32'h02000002});
        step(aesinv_pkg::AESINV_OP_UNSUB, 128'h020100, 1'b1, 1'b1);
        chk(result, 128'h52525252_52525252_52525252_526A0952);
        step(aesinv_pkg::AESINV_OP_WORDSUB, 128'h0100, 1'b1, 1'b1);
        chk(result, 128'h63637C63);
        x = {xs(), xs(), xs(), xs()};
        step(aesinv_pkg::AESINV_OP_UNMIX, colmat(x, 32'h01010302), 1'b1, 1'b1);
        chk(result, x);
        for (int i = 0; i < 8; i++) step(i[2:0], {xs(), xs(), xs(), xs()}, 1'b1, 1'b1);
        for (int i = 0; i < 400; i++) begin
            x = {xs(), xs(), xs(), xs()};
            step(x[2:0], {xs(), xs(), xs(), xs()}, x[5:3] != 3'h0, x[7:6] != 2'h0);
        end
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        chk(result, 128'h0);
        chk({127'h0, out_valid}, 128'h0);
        rst = 1'b0;
        last_r = '0;
        last_v = 1'b0;
        step(aesinv_pkg::AESINV_OP_CLMUL, {xs(), xs(), xs(), xs()}, 1'b1, 1'b1);
        step(aesinv_pkg::AESINV_OP_CLMUL, {64'hFFFFFFFFFFFFFFFF, 64'h8000000000000001}, 1'b1,
             1'b1);
        step(aesinv_pkg::AESINV_OP_UNROT, {xs(), xs(), xs(), xs()}, 1'b1, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
